/* File: verilog/sio_pkg.sv */
// constants, types and reset values of the clocked serial interface
//
// Overview of operation
// - one 8-bit shift register shifts serial input in and serial output out
// - clock source field: 11 osc, 10 osc half, 01 timer, 00 external slave
// - timer source toggles shift clock on each timer 2 underflow, halving it
// - reset selects slave mode with external shift clock
// - master drives shift clock, stops after 8 clocks at inactive level
// - slave takes shift clock from pin, ignores edges after the eighth
// - master: clock pin output, pin 3 general; slave: clock input, pin 3 ready
// - pin 1 carries serial output only while output enable is set
// - software loads nibbles, writes trigger, data shifts with the shift clock
// - serial output changes on the leading edge of the active clock
// - sample edge select picks leading (1) or trailing (0) edge for input
// - end of transfer found by counting 8 shift clock cycles
// - completion always sets done flag, interrupt only when enabled
// - shift register contents readable through the two data nibbles
// - bit order: 0 LSB first, 1 MSB first, both directions
// - slave ready inactive normally, active right after trigger write
// - ready drops at first active clock level or high nibble access
// - build-time polarity flips clock and ready levels and edges together
// - trigger reads 1 from trigger write until the 8 clocks finish
// - port select gives pins serial in, serial out, clock, ready
package sio_pkg;

  localparam int ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'hFF70;
  localparam logic [15:0] IDX_FORMAT = 16'hFF71;
  localparam logic [15:0] IDX_DATA_LOW = 16'hFF72;
  localparam logic [15:0] IDX_DATA_HIGH = 16'hFF73;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFFE2;
  localparam logic [15:0] IDX_IRQ_FLAG = 16'hFFF2;

  localparam int CTL_PORT_SEL = 0;
  localparam int CTL_TRIGGER = 1;
  localparam int CTL_OUT_EN = 2;
  localparam int FMT_SRC_LO = 0;
  localparam int FMT_SRC_HI = 1;
  localparam int FMT_EDGE = 2;
  localparam int FMT_ORDER = 3;
  localparam int FLAG_DONE = 0;

  localparam logic [1:0] CLK_SLAVE = 2'h0;
  localparam logic [1:0] CLK_TIMER = 2'h1;
  localparam logic [1:0] CLK_OSC_HALF = 2'h2;
  localparam logic [1:0] CLK_OSC = 2'h3;

  localparam logic [3:0] CYCLES_PER_BYTE = 4'h8;
  localparam int SYS_CLK_KHZ = 250000;
  localparam int MAX_SCLK_KHZ = 1000;
  localparam int MIN_SCLK_HALF_CYC = SYS_CLK_KHZ / MAX_SCLK_KHZ / 2;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} run_t;

  typedef struct packed {
    run_t run;
    logic port_sel;
    logic out_en;
    logic [1:0] clk_src;
    logic sample_edge;
    logic msb_first;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic done_flag;
    logic irq_en;
    logic irq;
    logic ready;
    logic sclk_act;
    logic out_bit;
    logic [2:0] osc_sync;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic sclk_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
  } state_t;

  localparam state_t STATE_RST = '0;

endpackage

/* File: verilog/sync_serial.sv */
// clocked 8-bit serial interface, master or slave, with apb registers
`timescale 1ns/100ps
`default_nettype none
module sync_serial import sio_pkg::*; #(
  parameter bit POSITIVE_POLARITY = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic low_speed_osc_i,
  input wire logic timer2_underflow_i,
  input wire logic [3:0] port_pin_i,
  output logic [3:0] port_pin_o,
  output logic [3:0] port_pin_oe_o,
  input wire logic [3:0] gpio_out_i,
  input wire logic [3:0] gpio_oe_i,
  output logic serial_done_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  state_t q;
  state_t next_q;

  logic inv;
  logic [15:0] idx;
  logic hit_ctl;
  logic hit_fmt;
  logic hit_low;
  logic hit_high;
  logic hit_mask;
  logic hit_flag;
  logic hit_any;
  logic access;
  logic wr;
  logic rd;
  logic master;
  logic running;
  logic osc_rise;
  logic osc_fall;
  logic tick;
  logic ext_act;
  logic ext_lead;
  logic ext_trail;
  logic lead;
  logic trail;
  logic sample;
  logic sin_bit;
  logic last;

  // polarity is a build option
  assign inv = ~POSITIVE_POLARITY;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign idx = paddr_i[ADDR_W-1:2];
  assign hit_ctl = idx == IDX_CONTROL;
  assign hit_fmt = idx == IDX_FORMAT;
  assign hit_low = idx == IDX_DATA_LOW;
  assign hit_high = idx == IDX_DATA_HIGH;
  assign hit_mask = idx == IDX_IRQ_MASK;
  assign hit_flag = idx == IDX_IRQ_FLAG;
  assign hit_any = hit_ctl | hit_fmt | hit_low | hit_high | hit_mask |
                   hit_flag;
  assign access = psel_i & penable_i & q.pready;
  assign wr = access & pwrite_i & hit_any;
  assign rd = access & ~pwrite_i & hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // shift clock sources and edges
  assign master = q.clk_src != CLK_SLAVE;
  assign running = q.run == ST_RUN;
  assign osc_rise = q.osc_sync[1] & ~q.osc_sync[2];
  assign osc_fall = ~q.osc_sync[1] & q.osc_sync[2];

  always_comb begin
    case (q.clk_src)
      CLK_OSC: begin
        tick = osc_rise | osc_fall;
      end
      CLK_OSC_HALF: begin
        tick = osc_rise;
      end
      CLK_TIMER: begin
        tick = timer2_underflow_i;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // external clock in active sense, from the second sync stage
  assign ext_act = q.pin_s2[2] ^ inv;
  assign ext_lead = ext_act & ~q.sclk_prev;
  assign ext_trail = ~ext_act & q.sclk_prev;

  // edges only count while running, later ones are masked
  assign lead = running & (master ? (tick & ~q.sclk_act) : ext_lead);
  assign trail = running & (master ? (tick & q.sclk_act) : ext_trail);
  assign sample = q.sample_edge ? lead : trail;
  assign sin_bit = q.pin_s2[0];
  assign last = trail & (q.cnt == CYCLES_PER_BYTE - 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_q = q;
    next_q.osc_sync = {q.osc_sync[1:0], low_speed_osc_i};
    next_q.pin_s1 = port_pin_i;
    next_q.pin_s2 = q.pin_s1;
    next_q.sclk_prev = ext_act;

    // apb: answer one cycle into the access phase
    next_q.pready = psel_i & penable_i & ~q.pready;
    next_q.pslverr = 1'b0;
    next_q.prdata = '0;
    if (psel_i & penable_i & ~q.pready) begin
      next_q.pslverr = ~hit_any;
      if (hit_ctl) begin
        next_q.prdata[CTL_PORT_SEL] = q.port_sel;
        next_q.prdata[CTL_TRIGGER] = running;
        next_q.prdata[CTL_OUT_EN] = q.out_en;
      end
      if (hit_fmt) begin
        next_q.prdata[FMT_SRC_HI:FMT_SRC_LO] = q.clk_src;
        next_q.prdata[FMT_EDGE] = q.sample_edge;
        next_q.prdata[FMT_ORDER] = q.msb_first;
      end
      if (hit_low) begin
        next_q.prdata[3:0] = q.shreg[3:0];
      end
      if (hit_high) begin
        next_q.prdata[3:0] = q.shreg[7:4];
      end
      if (hit_mask) begin
        next_q.prdata[0] = q.irq_en;
      end
      if (hit_flag) begin
        next_q.prdata[FLAG_DONE] = q.done_flag;
      end
    end

    // register writes
    if (wr & hit_ctl) begin
      next_q.port_sel = pwdata_i[CTL_PORT_SEL];
      next_q.out_en = pwdata_i[CTL_OUT_EN];
      if (pwdata_i[CTL_TRIGGER]) begin
        next_q.run = ST_RUN;
        next_q.cnt = '0;
        next_q.sclk_act = 1'b0;
        next_q.ready = ~master;
      end
    end
    if (wr & hit_fmt) begin
      next_q.clk_src = pwdata_i[FMT_SRC_HI:FMT_SRC_LO];
      next_q.sample_edge = pwdata_i[FMT_EDGE];
      next_q.msb_first = pwdata_i[FMT_ORDER];
    end
    if (wr & hit_low) begin
      next_q.shreg[3:0] = pwdata_i[3:0];
    end
    if (wr & hit_high) begin
      next_q.shreg[7:4] = pwdata_i[3:0];
    end
    if ((wr | rd) & hit_high) begin
      next_q.ready = 1'b0;
    end
    if (wr & hit_mask) begin
      next_q.irq_en = pwdata_i[0];
    end
    if (wr & hit_flag & pwdata_i[FLAG_DONE]) begin
      next_q.done_flag = 1'b0;
    end

    // master clock generation
    if (master & running & tick) begin
      next_q.sclk_act = ~q.sclk_act;
    end

    // shift engine; output on leading edge, input on chosen edge
    if (lead) begin
      next_q.out_bit = q.msb_first ? q.shreg[7] : q.shreg[0];
      next_q.ready = 1'b0;
    end
    if (sample) begin
      if (q.msb_first) begin
        next_q.shreg = {q.shreg[6:0], sin_bit};
      end else begin
        next_q.shreg = {sin_bit, q.shreg[7:1]};
      end
    end
    if (trail) begin
      next_q.cnt = q.cnt + 4'h1;
    end
    if (last) begin
      next_q.run = ST_IDLE;
      next_q.done_flag = 1'b1;
    end

    next_q.irq = next_q.done_flag & next_q.irq_en;

    // pin roles, general port otherwise
    next_q.pin_o = gpio_out_i;
    next_q.pin_oe = gpio_oe_i;
    if (q.port_sel) begin
      next_q.pin_oe[0] = 1'b0;
      if (q.out_en) begin
        next_q.pin_o[1] = q.out_bit;
        next_q.pin_oe[1] = 1'b1;
      end
      if (master) begin
        next_q.pin_o[2] = q.sclk_act ^ inv;
        next_q.pin_oe[2] = 1'b1;
      end else begin
        next_q.pin_oe[2] = 1'b0;
        next_q.pin_o[3] = q.ready ^ inv;
        next_q.pin_oe[3] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset gives slave mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign port_pin_o = q.pin_o;
  assign port_pin_oe_o = q.pin_oe;
  assign serial_done_irq_o = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic trig_wr;
  assign trig_wr = wr & hit_ctl & pwdata_i[CTL_TRIGGER];

  property p_trigger_runs;
    trig_wr |=> running && q.cnt == 4'h0;
  endproperty
  a_trigger_runs: assert property (p_trigger_runs)
    else $error("trigger did not start a transfer");

  property p_done_sets_flag;
    last |=> q.done_flag && !running && q.cnt == CYCLES_PER_BYTE;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("eighth clock did not finish the transfer");

  property p_irq_masked;
    !q.irq_en && !(wr & hit_mask) |=> !serial_done_irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised while masked");

  property p_count_bound;
    q.cnt <= CYCLES_PER_BYTE;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("shift count past eight");

  property p_master_idle_clock;
    master && !running |-> !q.sclk_act;
  endproperty
  a_master_idle_clock: assert property (p_master_idle_clock)
    else $error("master clock not idle after transfer");

  property p_ready_on_trigger;
    trig_wr && !master |=> q.ready;
  endproperty
  a_ready_on_trigger: assert property (p_ready_on_trigger)
    else $error("ready not raised by trigger in slave mode");

  property p_ready_drops;
    q.ready && lead |=> !q.ready;
  endproperty
  a_ready_drops: assert property (p_ready_drops)
    else $error("ready held past first active clock");

  property p_flag_clear;
    wr && hit_flag && pwdata_i[FLAG_DONE] && !last |=> !q.done_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("done flag not cleared by writing one");

  property p_serial_out_pin_gated;
    !(q.port_sel && q.out_en) |=> port_pin_oe_o[1] == $past(gpio_oe_i[1]);
  endproperty
  a_serial_out_pin_gated: assert property (p_serial_out_pin_gated)
    else $error("serial output driven while disabled");

  property p_slave_clock_input;
    q.port_sel && !master |=> !port_pin_oe_o[2] && port_pin_oe_o[3];
  endproperty
  a_slave_clock_input: assert property (p_slave_clock_input)
    else $error("slave pin roles wrong");

  property p_apb_answer;
    psel_i && penable_i && !q.pready |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not one cycle long");

  property p_out_on_lead;
    !lead |=> $stable(q.out_bit);
  endproperty
  a_out_on_lead: assert property (p_out_on_lead)
    else $error("serial output moved off the leading edge");

  property p_shreg_hold;
    !sample && !(wr && (hit_low || hit_high)) |=> $stable(q.shreg);
  endproperty
  a_shreg_hold: assert property (p_shreg_hold)
    else $error("shift register moved without a sample edge");

  property p_count_idle;
    !running && !trig_wr |=> $stable(q.cnt);
  endproperty
  a_count_idle: assert property (p_count_idle)
    else $error("shift count moved while stopped");

  property p_clock_pin;
    q.port_sel && master |=>
      port_pin_oe_o[2] && port_pin_o[2] == ($past(q.sclk_act) ^ inv);
  endproperty
  a_clock_pin: assert property (p_clock_pin)
    else $error("master clock pin does not follow the shift clock");

  property p_ready_pin;
    q.port_sel && !master |=> port_pin_o[3] == ($past(q.ready) ^ inv);
  endproperty
  a_ready_pin: assert property (p_ready_pin)
    else $error("ready pin does not follow the ready state");

  property p_flag_sticky;
    q.done_flag && !(wr && hit_flag && pwdata_i[FLAG_DONE]) |=> q.done_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("done flag lost without a write of one");

  property p_flag_set_by_end;
    !q.done_flag && !last |=> !q.done_flag;
  endproperty
  a_flag_set_by_end: assert property (p_flag_set_by_end)
    else $error("done flag set without the eighth clock");

  property p_sin_lsb;
    sample && !q.msb_first |=> q.shreg[7] == $past(sin_bit);
  endproperty
  a_sin_lsb: assert property (p_sin_lsb)
    else $error("input bit not taken at the top in lsb order");

  property p_sin_msb;
    sample && q.msb_first |=> q.shreg[0] == $past(sin_bit);
  endproperty
  a_sin_msb: assert property (p_sin_msb)
    else $error("input bit not taken at the bottom in msb order");

  c_master_done: cover property (master && last);
  c_slave_done: cover property (!master && last);
  c_ready_cleared_by_access: cover property (q.ready && (wr | rd) && hit_high);
  c_done_and_clear: cover property (last && wr && hit_flag);

endmodule // sync_serial
`default_nettype wire

/* File: verification/sio_peer.sv */
// behavioural far-side serial device: master or slave of the block
`timescale 1ns/100ps
`default_nettype none
module sio_peer (
  input wire logic sys_clk_i,
  input wire logic clk_pin_i,
  input wire logic serial_out_pin_i,
  input wire logic arm_i,
  input wire logic msb_first_i,
  input wire logic sample_lead_i,
  input wire logic [7:0] tx_i,
  output logic sin_o,
  output logic clk_o,
  output logic [7:0] rx_o
);
  int idx = 8;
  int cnt = 8;
  logic adv = 1'h0;
  initial begin
    sin_o = 1'h0;
    clk_o = 1'h0;
    rx_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // data set up before the sampling edge, changed only after it
  always @(posedge arm_i or posedge clk_pin_i or negedge clk_pin_i) begin
    if (arm_i) begin
      idx = 0;
      cnt = 0;
      adv = 1'h0;
    end else if (clk_pin_i == sample_lead_i) begin
      adv = 1'h1;
    end else if (adv) begin
      idx++;
      adv = 1'h0;
    end
    if (!arm_i && !clk_pin_i && cnt < 8) begin
      cnt++;
      rx_o = msb_first_i ? {rx_o[6:0], serial_out_pin_i} : {serial_out_pin_i, rx_o[7:1]};
    end
    // released line shows the inverse of its last level
    if (idx < 8)
      sin_o = tx_i[msb_first_i ? 7 - idx : idx];
    else
      sin_o = ~sin_o;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock idles low between frames
  task automatic drive_clock(input int cycles, input int half);
    repeat (cycles) begin
      repeat (half) @(posedge sys_clk_i);
      clk_o <= 1'h1;
      repeat (half) @(posedge sys_clk_i);
      clk_o <= 1'h0;
    end
  endtask
endmodule // sio_peer
`default_nettype wire

/* File: verification/sync_serial_tb_top.sv */
// self-checking bench for the clocked serial interface
`timescale 1ns/100ps
`default_nettype none
module sync_serial_tb_top import sio_pkg::*;;
  logic clk = 1'h0, rst = 1'h1;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, perr;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, osc = 1'h0, tmr = 1'h0;
  logic [3:0] pin_i, pin_o, pin_oe, gout = 4'h5, goe = 4'hD;
  logic arm = 1'h0, pmsb = 1'h0, plead = 1'h0, psin, pclk;
  logic [7:0] ptx = 8'h00, prx;
  logic [3:0] fmts [4] = '{4'h3, 4'hE, 4'h9, 4'h7};
  logic [7:0] dvs [4] = '{8'hA5, 8'h5A, 8'h81, 8'h3C};
  int err_total = 0, check_count = 0, tick = 0;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick % 75 == 74) osc <= ~osc;
    tmr <= (tick % 130 == 129);
  end
  // released serial out and ready lines fall to the pull-down level
  assign pin_i[0] = pin_oe[0] ? pin_o[0] : psin;
  assign pin_i[1] = pin_oe[1] & pin_o[1];
  assign pin_i[2] = pin_oe[2] ? pin_o[2] : pclk;
  assign pin_i[3] = pin_oe[3] & pin_o[3];

  sync_serial DUT (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .low_speed_osc_i(osc), .timer2_underflow_i(tmr), .port_pin_i(pin_i),
    .port_pin_o(pin_o), .port_pin_oe_o(pin_oe), .gpio_out_i(gout),
    .gpio_oe_i(goe), .serial_done_irq_o(irq));
  sio_peer peer (.sys_clk_i(clk), .clk_pin_i(pin_i[2]), .serial_out_pin_i(pin_i[1]),
    .arm_i(arm), .msb_first_i(pmsb), .sample_lead_i(plead), .tx_i(ptx),
    .sin_o(psin), .clk_o(pclk), .rx_o(prx));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, logic [15:0] idx, logic [3:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'h1;
    pwr <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {28'h0, d};
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    r = prdata;
    perr = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] idx, logic [3:0] d);
    logic [31:0] r;
    apb(1'h1, idx, d, r);
  endtask
  task automatic rreg(input logic [15:0] idx, logic [31:0] e);
    logic [31:0] r;
    apb(1'h0, idx, 4'h0, r);
    chk($sformatf("reg %h", idx), e, r);
  endtask
  task automatic wait_idle;
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      apb(1'h0, IDX_CONTROL, 4'h0, r);
      n++;
    end while (r[1] !== 1'h0 && n < 2000);
    chk("trigger status", 32'h5, r);
  endtask
  task automatic load(input logic [3:0] fmt, logic [7:0] dv, pv, logic ien);
    wr(IDX_FORMAT, fmt);
    wr(IDX_IRQ_MASK, {3'h0, ien});
    wr(IDX_DATA_LOW, dv[3:0]);
    wr(IDX_DATA_HIGH, dv[7:4]);
    ptx <= pv;
    pmsb <= fmt[3];
    plead <= fmt[2];
    arm <= 1'h1;
    @(posedge clk);
    arm <= 1'h0;
    wr(IDX_CONTROL, 4'h7);
  endtask
  task automatic done_chk(input logic [7:0] dv, pv, logic ien);
    chk("peer rx", dv, prx);
    rreg(IDX_DATA_LOW, pv[3:0]);
    rreg(IDX_DATA_HIGH, pv[7:4]);
    rreg(IDX_IRQ_FLAG, 32'h1);
    chk("irq", ien, irq);
    wr(IDX_IRQ_FLAG, 4'h0);
    rreg(IDX_IRQ_FLAG, 32'h1);
    wr(IDX_IRQ_FLAG, 4'h1);
    rreg(IDX_IRQ_FLAG, 32'h0);
    chk("irq clear", 0, irq);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    chk("gpio oe", 4'hD, pin_oe);
    chk("gpio out", 4'h5, pin_o);
    rreg(IDX_CONTROL, 32'h0);
    rreg(IDX_FORMAT, 32'h0);
    rreg(IDX_IRQ_MASK, 32'h0);
    rreg(IDX_IRQ_FLAG, 32'h0);
    apb(1'h0, 16'h0123, 4'h0, rd);
    chk("unmapped err", 1, perr);
    chk("unmapped data", 0, rd);
    wr(IDX_CONTROL, 4'h1);
    repeat (3) @(posedge clk);
    chk("slave oe", 4'h8, pin_oe & 4'hE);
    chk("ready idle", 0, pin_o[3]);
    for (int i = 0; i < 4; i++) begin
      load(fmts[i], dvs[i], ~dvs[i], i[0]);
      rreg(IDX_CONTROL, 32'h7);
      chk("master oe", 4'hE, pin_oe & 4'hE);
      wait_idle;
      chk("clock idle", 0, pin_o[2]);
      done_chk(dvs[i], ~dvs[i], i[0]);
    end
    load(4'h0, 8'h96, 8'h4B, 1'h1);
    repeat (3) @(posedge clk);
    chk("ready on", 1, pin_o[3]);
    chk("clock input", 0, pin_oe[2]);
    rreg(IDX_DATA_HIGH, 32'h9);
    repeat (2) @(posedge clk);
    chk("ready access", 0, pin_o[3]);
    wr(IDX_CONTROL, 4'h7);
    repeat (2) @(posedge clk);
    chk("ready again", 1, pin_o[3]);
    peer.drive_clock(10, MIN_SCLK_HALF_CYC + 5);
    wait_idle;
    chk("ready edge", 0, pin_o[3]);
    done_chk(8'h96, 8'h4B, 1'h1);
    report_and_stop;
  end
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
endmodule // sync_serial_tb_top
`default_nettype wire
